// ===== src/frx_pkg.sv
package frx_pkg;
    // instruction word and data widths
    localparam int WORD_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int REG_DEPTH = 128;
    // field positions inside the instruction word
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int TGT_BIT = 7;
    localparam int IDX_MSB = 6;
    // opcode values of the upper six bits
    localparam logic [5:0] OPC_INCR = 6'h0a;
    localparam logic [5:0] OPC_COPY = 6'h08;
    localparam logic [5:0] OPC_ZERO = 6'h00;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    // decoded operation
    typedef enum logic [1:0] {
        FRX_NONE = 2'b00,
        FRX_INCR = 2'b01,
        FRX_COPY = 2'b10,
        FRX_STORE = 2'b11
    } frx_op_t;
    // execute pipeline state
    typedef enum logic [0:0] {
        FRX_IDLE = 1'b0,
        FRX_EXEC = 1'b1
    } frx_state_t;
endpackage : frx_pkg

// ===== src/frx_file_mem.sv
`timescale 1ns/100ps
module frx_file_mem
    import frx_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // read port, data registered
    input wire logic [frx_pkg::ADDR_W-1:0] rdAddr,
    output logic [frx_pkg::DATA_W-1:0] rdData,
    // write port
    input wire logic wrEn,
    input wire logic [frx_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [frx_pkg::DATA_W-1:0] wrData
);
    logic [DATA_W-1:0] mem [REG_DEPTH];

    // contents are not reset, like real file ram
    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : frx_file_mem

// ===== src/frx_exec.sv
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - increment op adds one, sets zero
// RULE_02 - increment target bit picks acc or register
// RULE_03 - copy op reads register unchanged
// RULE_04 - copy target bit picks acc or register
// RULE_05 - copy updates zero for both targets
// RULE_06 - store op writes acc, flags untouched
// RULE_07 - zero set on zero result, else cleared
module frx_exec
    import frx_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // instruction from fetch
    input wire logic instrValid,
    input wire logic [frx_pkg::WORD_W-1:0] instrWord,
    // results
    output logic [frx_pkg::DATA_W-1:0] accOut,
    output logic zeroFlag,
    output logic done,
    output logic wrStrobe,
    output logic [frx_pkg::ADDR_W-1:0] wrIndex,
    output logic [frx_pkg::DATA_W-1:0] wrValue,
    output logic illegal
);
    import frx_pkg::*;

    // classify one instruction word
    function automatic frx_op_t decodeOp(input logic [WORD_W-1:0] w);
        frx_op_t op;
        op = FRX_NONE;
        if (w[OPC_MSB:OPC_LSB] == OPC_INCR)
        begin
            op = FRX_INCR;
        end
        else if (w[OPC_MSB:OPC_LSB] == OPC_COPY)
        begin
            op = FRX_COPY;
        end
        // the store pattern needs bit 7 set; with it clear the word is not ours
        else if (w[OPC_MSB:OPC_LSB] == OPC_ZERO && w[TGT_BIT])
        begin
            op = FRX_STORE;
        end
        return op;
    endfunction : decodeOp

    // zero test of a produced value, shared by the ops that touch the flag
    function automatic logic isZero(input logic [DATA_W-1:0] v);
        return v == '0;
    endfunction : isZero

    logic [DATA_W-1:0] memRdData;
    logic memWrEn;
    logic [ADDR_W-1:0] memWrAddr;
    logic [DATA_W-1:0] memWrData;

    // pipeline registers and their next values
    frx_state_t state_reg, state_next;
    frx_op_t op_reg, op_next;
    logic tgt_reg, tgt_next;
    logic [ADDR_W-1:0] idx_reg, idx_next;
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic done_reg, done_next;
    logic wrStrobe_reg, wrStrobe_next;
    logic [ADDR_W-1:0] wrIndex_reg, wrIndex_next;
    logic [DATA_W-1:0] wrValue_reg, wrValue_next;
    logic illegal_reg, illegal_next;
    // the ram write of one op lands on the very edge that reads the next
    // op's index, so that read returns the old word; the hit is noted at
    // take time, since the strobe is gone by the execute cycle
    logic byp_reg, byp_next;
    // working value of the execute cycle
    logic [DATA_W-1:0] result;

    // file register array; read data arrive one cycle after the index
    frx_file_mem u_mem (
        .ref_clk(ref_clk),
        .rdAddr(instrWord[IDX_MSB:0]),
        .rdData(memRdData),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData)
    );

    // write port follows the registered write strobe outputs
    assign memWrEn = wrStrobe_reg;
    assign memWrAddr = wrIndex_reg;
    assign memWrData = wrValue_reg;

    // next-state and execute logic
    always_comb
    begin
        state_next = state_reg;
        op_next = op_reg;
        tgt_next = tgt_reg;
        idx_next = idx_reg;
        acc_next = acc_reg;
        zero_next = zero_reg;
        done_next = 1'b0;
        wrStrobe_next = 1'b0;
        wrIndex_next = wrIndex_reg;
        wrValue_next = wrValue_reg;
        illegal_next = 1'b0;
        byp_next = 1'b0;
        result = memRdData;
        case (state_reg)
            FRX_IDLE:
            begin
                if (instrValid)
                begin
                    // latch the fields while the ram reads the index
                    op_next = decodeOp(instrWord);
                    tgt_next = instrWord[TGT_BIT];
                    idx_next = instrWord[IDX_MSB:0];
                    // last op still writing the same index: use its value
                    byp_next = wrStrobe_reg && wrIndex_reg == instrWord[IDX_MSB:0];
                    if (decodeOp(instrWord) == FRX_NONE)
                    begin
                        illegal_next = 1'b1; // other opcodes are not ours
                    end
                    else
                    begin
                        state_next = FRX_EXEC;
                    end
                end
            end
            FRX_EXEC:
            begin
                // a read-after-write to the same index bypasses the stale ram word;
                // wrValue_reg still holds that write, nothing has written since
                if (byp_reg)
                begin
                    result = wrValue_reg;
                end
                case (op_reg)
                    FRX_INCR:
                    begin
                        result = DATA_W'(result + 8'h01); // RULE_01
                        zero_next = isZero(result); // RULE_07
                    end
                    FRX_COPY:
                    begin
                        zero_next = isZero(result); // RULE_05
                    end
                    FRX_STORE:
                    begin
                        result = acc_reg; // RULE_06
                    end
                    default:
                    begin
                        result = memRdData;
                    end
                endcase
                // store op always targets the register; flags untouched
                if (op_reg == FRX_STORE || tgt_reg)
                begin
                    wrStrobe_next = 1'b1; // RULE_02 RULE_04
                    wrIndex_next = idx_reg;
                    wrValue_next = result;
                end
                else
                begin
                    acc_next = result; // RULE_02 RULE_04 RULE_03
                end
                // one instruction cycle spans two clocks of this block
                done_next = 1'b1;
                state_next = FRX_IDLE;
            end
            default:
            begin
                state_next = FRX_IDLE;
            end
        endcase
    end

    // state registers
    // the ram sits outside this process and keeps no reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= FRX_IDLE;
            op_reg <= FRX_NONE;
            tgt_reg <= 1'b0;
            idx_reg <= '0;
            acc_reg <= ACC_RST;
            zero_reg <= ZERO_RST;
            done_reg <= 1'b0;
            wrStrobe_reg <= 1'b0;
            wrIndex_reg <= '0;
            wrValue_reg <= '0;
            illegal_reg <= 1'b0;
            byp_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            op_reg <= op_next;
            tgt_reg <= tgt_next;
            idx_reg <= idx_next;
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            done_reg <= done_next;
            wrStrobe_reg <= wrStrobe_next;
            wrIndex_reg <= wrIndex_next;
            wrValue_reg <= wrValue_next;
            illegal_reg <= illegal_next;
            byp_reg <= byp_next;
        end
    end

    // outputs straight from flip-flops
    assign accOut = acc_reg;
    assign zeroFlag = zero_reg;
    assign done = done_reg;
    assign wrStrobe = wrStrobe_reg;
    assign wrIndex = wrIndex_reg;
    assign wrValue = wrValue_reg;
    assign illegal = illegal_reg;
endmodule : frx_exec

// ===== tb/frx_exec_props.sv
`timescale 1ns/100ps
module frx_exec_props
    import frx_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // instruction
    input wire logic instrValid,
    input wire logic [frx_pkg::WORD_W-1:0] instrWord,
    // results
    input wire logic [frx_pkg::DATA_W-1:0] accOut,
    input wire logic zeroFlag,
    input wire logic done,
    input wire logic wrStrobe,
    input wire logic [frx_pkg::ADDR_W-1:0] wrIndex,
    input wire logic [frx_pkg::DATA_W-1:0] wrValue,
    input wire logic illegal
);
    logic busyReg, busyNext, legal, isIncr, isCopy, isStore, resZero;
    logic [WORD_W-1:0] wReg, wNext;
    // illegal words never start a busy cycle, so only legal takes count
    always_comb
    begin
        legal = instrWord[13:8] == OPC_INCR || instrWord[13:8] == OPC_COPY;
        legal = legal || instrWord[13:7] == 7'h01;
        busyNext = !busyReg && instrValid && legal;
        wNext = busyNext ? instrWord : wReg;
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        busyReg <= rst ? 1'b0 : busyNext;
        wReg <= rst ? 14'h0000 : wNext;
    end
    // decode of the word in flight, held until its done
    assign isIncr = wReg[13:8] == OPC_INCR;
    assign isCopy = wReg[13:8] == OPC_COPY;
    assign isStore = wReg[13:7] == 7'h01;
    assign resZero = (wReg[7] ? wrValue : accOut) == 8'h00;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_take_done: assert property (busyNext |-> ##2 done && !illegal)
        else $error("no done after take");
    a_incr_zero: assert property (done && isIncr |-> zeroFlag == resZero)
        else $error("increment zero wrong");
    a_incr_target: assert property (done && isIncr |-> wrStrobe == wReg[7])
        else $error("increment target wrong");
    a_copy_target: assert property (done && isCopy |-> wrStrobe == wReg[7])
        else $error("copy target wrong");
    a_copy_zero: assert property (done && isCopy |-> zeroFlag == resZero)
        else $error("copy zero wrong");
    a_store_write: assert property (done && isStore |-> wrStrobe && wrIndex == wReg[6:0]
        && wrValue == accOut && $stable(zeroFlag))
        else $error("store write wrong");
    a_zero_hold: assert property (!done |-> $stable(zeroFlag))
        else $error("zero moved without done");
endmodule : frx_exec_props
bind frx_exec frx_exec_props i_props (.ref_clk(ref_clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .accOut(accOut), .zeroFlag(zeroFlag), .done(done),
    .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrValue(wrValue), .illegal(illegal));

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
    import frx_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, zeroFlag, done, wrStrobe, illegal;
    logic z = 1'b0;
    logic [13:0] instrWord = 14'h0000, w;
    logic [7:0] accOut, wrValue, r, acc = 8'h00, val = 8'h00;
    logic [6:0] wrIndex, idx = 7'h00;
    logic [7:0] mem [128];
    logic [25:0] q [$], got;
    int miscompares = 0, nTests = 0, seed = 31, i;
    frx_exec i_dut (.ref_clk(ref_clk), .rst(rst), .instrValid(instrValid),
        .instrWord(instrWord), .accOut(accOut), .zeroFlag(zeroFlag), .done(done),
        .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrValue(wrValue), .illegal(illegal));
    always #50 ref_clk = ~ref_clk;
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // note expected outputs, then offer the word for one instruction slot
    task automatic exe(input logic [13:0] wd);
        logic ill, wr;
        ill = 1'b0;
        wr = wd[7];
        r = mem[wd[6:0]];
        if (wd[13:8] == OPC_INCR)
            r = r + 8'h01;
        if (wd[13:7] == 7'h01)
            r = acc;
        else if (wd[13:8] == OPC_INCR || wd[13:8] == OPC_COPY)
            z = r == 8'h00;
        else
            ill = 1'b1;
        wr = wr && !ill;
        if (!ill && !wr)
            acc = r;
        if (wr)
        begin
            mem[wd[6:0]] = r;
            idx = wd[6:0];
            val = r;
        end
        q.push_back({ill, wr, idx, val, acc, z});
        instrValid = 1'b1;
        instrWord = wd;
        @(negedge ref_clk);
        // legal words stay offered in the busy cycle, which must ignore them
        instrValid = !ill;
        @(negedge ref_clk);
    endtask : exe
    task automatic test_done();
        $display("compares %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // pair each completion with the oldest note
    always @(negedge ref_clk)
    begin
        if (done === 1'b1 || illegal === 1'b1)
        begin
            got = q.size() > 0 ? q.pop_front() : 'x;
            nTests++;
            if ({illegal, wrStrobe, wrIndex, wrValue, accOut, zeroFlag} !== got)
            begin
                miscompares++;
                $display("CHECK FAILED outputs expected %h seen %h", got,
                    {illegal, wrStrobe, wrIndex, wrValue, accOut, zeroFlag});
            end
        end
    end
    initial
    begin
        #(100 * 4000);
        miscompares++;
        test_done();
    end
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        // file is not reset, so clear it with zero acc first
        for (i = 0; i < 128; i++)
            exe({7'h01, i[6:0]});
        exe({OPC_COPY, 1'b1, 7'h05});
        exe({OPC_INCR, 1'b0, 7'h05});
        exe({7'h01, 7'h05});
        exe({OPC_COPY, 1'b0, 7'h00});
        $display("basic ops done");
        for (i = 0; i < 256; i++)
            exe({OPC_INCR, 1'b1, 7'h7f});
        exe(14'h3fff);
        exe(14'h0005);
        $display("wrap and illegal done");
        for (i = 0; i < 300; i++)
        begin
            w = 14'(rnd());
            case (w[13:12])
                2'h0: w[13:8] = OPC_INCR;
                2'h1: w[13:8] = OPC_COPY;
                2'h2: w[13:7] = 7'h01;
                default: ;
            endcase
            exe(w);
        end
        instrValid = 1'b0;
        repeat (4) @(negedge ref_clk);
        $display("random mix done");
        if (q.size() != 0)
        begin
            miscompares++;
            $display("CHECK FAILED pending notes expected 0 seen %0d", q.size());
        end
        test_done();
    end
endmodule : tb
